// File: src/host_port_pin_mux.v
// pin-role multiplexer for the 16-pin parallel host port
// assumes pins are asynchronous; tristate wires are resolved outside
// from pin_out and pin_oe_n; registers sit behind an axi4-lite slave
//
// Operation
// - non-muxed host mode: lines 0-7 are data
// - muxed host mode: lines 0-7 carry address and data
// - gpio mode: each pin follows direction register
// - non-muxed: pin 8 is address bit 0
// - muxed: pin 8 is polarity-programmable address strobe
// - muxed: pin 9 becomes address bit 8
// - muxed: pin 10 becomes address bit 9
// - single strobe: pin 11 is read/write direction
// - double strobe: pin 11 is read strobe
// - single strobe: pin 12 is data strobe
// - double strobe: pin 12 is write strobe
// - every pin has programmable polarity, and programmable direction in gpio mode
// - pin 13 chip select, or address bit 10
// - request outputs: single or transmit/receive, open-drain option
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "host_pin_consts.vh"
module host_port_pin_mux #(
  parameter NPIN = 16,
  parameter AW   = 8
) (
  input  wire            sys_clk,         // system clock, 10 MHz
  input  wire            rst_n,           // async reset, active low
  input  wire [AW-1:0]   s_awaddr,        // axi write address
  input  wire            s_awvalid,       // axi write address valid
  output wire            s_awready,       // axi write address ready
  input  wire [31:0]     s_wdata,         // axi write data
  input  wire [3:0]      s_wstrb,         // axi write strobes
  input  wire            s_wvalid,        // axi write data valid
  output wire            s_wready,        // axi write data ready
  output wire [1:0]      s_bresp,         // axi write response
  output wire            s_bvalid,        // axi write response valid
  input  wire            s_bready,        // axi write response ready
  input  wire [AW-1:0]   s_araddr,        // axi read address
  input  wire            s_arvalid,       // axi read address valid
  output wire            s_arready,       // axi read address ready
  output wire [31:0]     s_rdata,         // axi read data
  output wire [1:0]      s_rresp,         // axi read response
  output wire            s_rvalid,        // axi read data valid
  input  wire            s_rready,        // axi read data ready
  input  wire [NPIN-1:0] pin_in,          // pin levels seen at the pads
  output reg  [NPIN-1:0] pin_out,         // pin drive values
  output reg  [NPIN-1:0] pin_oe_n,        // pin drive enables, low drives
  input  wire [7:0]      core_rdata,      // byte returned on host reads
  input  wire            req_single,      // core asks for host service
  input  wire            req_tx,          // core transmit request
  input  wire            req_rx,          // core receive request
  output reg  [7:0]      host_byte_r,     // byte on the shared lines
  output reg  [10:0]     host_addr_r,     // decoded host address
  output reg             addr_strobe_r,   // address strobe asserted
  output reg             rw_read_r,       // single strobe: host reads
  output reg             data_strobe_r,   // any data strobe asserted
  output reg             read_strobe_r,   // read cycle in progress
  output reg             write_strobe_r,  // write cycle in progress
  output reg             chip_sel_r,      // device selected
  output reg             host_ack_r       // acknowledge input asserted
);

  // register file
  reg  [`CTRL_W-1:0] port_ctrl_r;
  reg  [NPIN-1:0]    pin_pol_r;
  reg  [NPIN-1:0]    pin_dir_r;
  reg  [NPIN-1:0]    gpio_out_r;

  wire               wr_pulse;
  wire [AW-1:0]      wr_addr;
  wire [31:0]        wr_data;
  wire [3:0]         wr_strb;
  wire [NPIN-1:0]    pin_sync;
  reg  [31:0]        rd_data;

  // pin registers hold 16 bits; upper lanes are ignored and read as zero
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge16[7:0]  = strb[0] ? data[7:0]  : old[7:0];
      merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  function reg_hit;
    input [AW-1:0] addr;
    begin
      reg_hit = (addr == `OFS_PORT_CTRL) || (addr == `OFS_PIN_POL) ||
                (addr == `OFS_PIN_DIR) || (addr == `OFS_GPIO_OUT) ||
                (addr == `OFS_PIN_LEVEL) || (addr == `OFS_HOST_STAT);
    end
  endfunction

  // request pin drive as {value, oe_n}; open-drain only pulls low
  function [1:0] req_drive;
    input req;
    input pol;
    input od;
    reg   lvl;
    begin
      lvl = req ^ pol;
      if (od) begin
        req_drive = {1'b0, lvl};
      end else begin
        req_drive = {lvl, 1'b0};
      end
    end
  endfunction

  axil_reg_slave #(
    .AW (AW)
  ) u_bus (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_pulse  (wr_pulse),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_hit    (reg_hit(wr_addr)),
    .rd_data   (rd_data),
    .rd_hit    (reg_hit(s_araddr))
  );

  pin_sync2 #(
    .WIDTH (NPIN)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // control fields, each chosen independently
  wire host_fn  = port_ctrl_r[`CTRL_HOST_FN];
  wire mux_bus  = port_ctrl_r[`CTRL_MUX_BUS];
  wire dual_stb = port_ctrl_r[`CTRL_DUAL_STB];
  wire dual_req = port_ctrl_r[`CTRL_DUAL_REQ];
  wire req_od   = port_ctrl_r[`CTRL_REQ_OD];

  // asserted-high view of every pin after its polarity bit
  wire [NPIN-1:0] lvl = pin_sync ^ pin_pol_r;

  reg  as_act;
  reg  rd_act;
  reg  wr_act;
  reg  ds_act;
  reg  cs_act;
  reg  ack_act;
  reg  drive_data;

  always @* begin
    as_act  = mux_bus & lvl[`PIN_ADDR0];
    cs_act  = mux_bus | lvl[`PIN_CS];
    ack_act = ~dual_req & lvl[`PIN_ACK];
    if (dual_stb) begin
      rd_act = lvl[`PIN_RW];
      wr_act = lvl[`PIN_DS];
      ds_act = rd_act | wr_act;
    end else begin
      // direction is only meaningful while the strobe is asserted
      ds_act = lvl[`PIN_DS];
      rd_act = ds_act & lvl[`PIN_RW];
      wr_act = ds_act & ~lvl[`PIN_RW];
    end
    drive_data = host_fn & cs_act & rd_act;
  end

  // next pin drive
  reg [NPIN-1:0] pin_out_nxt;
  reg [NPIN-1:0] pin_oe_n_nxt;
  reg [1:0]      req_a;
  reg [1:0]      req_b;

  always @* begin
    req_a = req_drive(dual_req ? req_tx : req_single, pin_pol_r[`PIN_REQ], req_od);
    req_b = req_drive(req_rx, pin_pol_r[`PIN_ACK], req_od);
    if (host_fn) begin
      pin_out_nxt  = {NPIN{1'b0}};
      pin_oe_n_nxt = {NPIN{1'b1}};
      pin_out_nxt[7:0]  = core_rdata ^ pin_pol_r[7:0];
      pin_oe_n_nxt[7:0] = {8{~drive_data}};
      pin_out_nxt[`PIN_REQ]  = req_a[1];
      pin_oe_n_nxt[`PIN_REQ] = req_a[0];
      if (dual_req) begin
        pin_out_nxt[`PIN_ACK]  = req_b[1];
        pin_oe_n_nxt[`PIN_ACK] = req_b[0];
      end
    end else begin
      pin_out_nxt  = gpio_out_r ^ pin_pol_r;
      pin_oe_n_nxt = ~pin_dir_r;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out  <= {NPIN{1'b0}};
      pin_oe_n <= {NPIN{1'b1}};
    end else begin
      pin_out  <= pin_out_nxt;
      pin_oe_n <= pin_oe_n_nxt;
    end
  end

  // decoded host signals toward the core
  reg [10:0] host_addr_nxt;

  always @* begin
    host_addr_nxt = 11'h000;
    if (mux_bus) begin
      // low byte is captured while the address strobe is up
      host_addr_nxt[7:0] = as_act ? lvl[7:0] : host_addr_r[7:0];
      host_addr_nxt[8]   = lvl[`PIN_ADDR1];
      host_addr_nxt[9]   = lvl[`PIN_ADDR2];
      host_addr_nxt[10]  = lvl[`PIN_CS];
    end else begin
      host_addr_nxt[0] = lvl[`PIN_ADDR0];
      host_addr_nxt[1] = lvl[`PIN_ADDR1];
      host_addr_nxt[2] = lvl[`PIN_ADDR2];
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_byte_r    <= 8'h00;
      host_addr_r    <= 11'h000;
      addr_strobe_r  <= 1'b0;
      rw_read_r      <= 1'b0;
      data_strobe_r  <= 1'b0;
      read_strobe_r  <= 1'b0;
      write_strobe_r <= 1'b0;
      chip_sel_r     <= 1'b0;
      host_ack_r     <= 1'b0;
    end else if (host_fn) begin
      host_byte_r    <= lvl[7:0];
      host_addr_r    <= host_addr_nxt;
      addr_strobe_r  <= as_act;
      rw_read_r      <= ~dual_stb & lvl[`PIN_RW];
      data_strobe_r  <= ds_act;
      read_strobe_r  <= rd_act;
      write_strobe_r <= wr_act;
      chip_sel_r     <= cs_act;
      host_ack_r     <= ack_act;
    end else begin
      // gpio mode: no host roles, so the core sees idle signals
      host_byte_r    <= 8'h00;
      host_addr_r    <= 11'h000;
      addr_strobe_r  <= 1'b0;
      rw_read_r      <= 1'b0;
      data_strobe_r  <= 1'b0;
      read_strobe_r  <= 1'b0;
      write_strobe_r <= 1'b0;
      chip_sel_r     <= 1'b0;
      host_ack_r     <= 1'b0;
    end
  end

  // register writes
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_ctrl_r <= `CTRL_RST;
      pin_pol_r   <= `PIN_RST;
      pin_dir_r   <= `PIN_RST;
      gpio_out_r  <= `PIN_RST;
    end else if (wr_pulse) begin
      case (wr_addr)
        `OFS_PORT_CTRL: begin
          if (wr_strb[0]) begin
            port_ctrl_r <= wr_data[`CTRL_W-1:0];
          end
        end
        `OFS_PIN_POL:  pin_pol_r  <= merge16(pin_pol_r, wr_data, wr_strb);
        `OFS_PIN_DIR:  pin_dir_r  <= merge16(pin_dir_r, wr_data, wr_strb);
        `OFS_GPIO_OUT: gpio_out_r <= merge16(gpio_out_r, wr_data, wr_strb);
        default: begin
        end
      endcase
    end
  end

  // register reads, answered from the address on the read channel
  always @* begin
    case (s_araddr)
      `OFS_PORT_CTRL: rd_data = {27'h0, port_ctrl_r};
      `OFS_PIN_POL:   rd_data = {16'h0, pin_pol_r};
      `OFS_PIN_DIR:   rd_data = {16'h0, pin_dir_r};
      `OFS_GPIO_OUT:  rd_data = {16'h0, gpio_out_r};
      `OFS_PIN_LEVEL: rd_data = {16'h0, lvl};
      `OFS_HOST_STAT: rd_data = {24'h0, host_ack_r, chip_sel_r, write_strobe_r,
                                 read_strobe_r, data_strobe_r, rw_read_r,
                                 addr_strobe_r, drive_data};
      default:        rd_data = 32'h0;
    endcase
  end

endmodule
`default_nettype wire

// File: common/host_pin_consts.vh
// constants for the host port pin multiplexer and its register slave
// assumes byte addressing on the register bus, one 32-bit word per register
`ifndef HOST_PIN_CONSTS_VH
`define HOST_PIN_CONSTS_VH

// register byte offsets
`define OFS_PORT_CTRL   8'h00
`define OFS_PIN_POL     8'h04
`define OFS_PIN_DIR     8'h08
`define OFS_GPIO_OUT    8'h0c
`define OFS_PIN_LEVEL   8'h10
`define OFS_HOST_STAT   8'h14

// port control fields
`define CTRL_HOST_FN    0
`define CTRL_MUX_BUS    1
`define CTRL_DUAL_STB   2
`define CTRL_DUAL_REQ   3
`define CTRL_REQ_OD     4
`define CTRL_W          5
`define CTRL_RST        5'h00
`define PIN_RST         16'h0000

// pin positions on the port
`define PIN_ADDR0       8
`define PIN_ADDR1       9
`define PIN_ADDR2       10
`define PIN_RW          11
`define PIN_DS          12
`define PIN_CS          13
`define PIN_REQ         14
`define PIN_ACK         15

// bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// File: src/pin_sync2.v
// two-stage synchroniser for the port pin inputs
// assumes the pins are asynchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none
module pin_sync2 #(
  parameter WIDTH = 16
) (
  input  wire             sys_clk,  // system clock
  input  wire             rst_n,    // async reset, active low
  input  wire [WIDTH-1:0] async_in, // raw pin levels
  output reg  [WIDTH-1:0] sync_out  // levels after two flops
);

  reg [WIDTH-1:0] meta_r;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule
`default_nettype wire

// File: src/axil_reg_slave.v
// axi4-lite slave front end: takes address and data in either order,
// hands one write pulse to the register file and captures its read data
// assumes the register file decodes and answers combinationally
`timescale 1ns/10ps
`default_nettype none
`include "host_pin_consts.vh"
module axil_reg_slave #(
  parameter AW = 8
) (
  input  wire          sys_clk,       // system clock
  input  wire          rst_n,         // async reset, active low
  input  wire [AW-1:0] s_awaddr,      // write address
  input  wire          s_awvalid,     // write address valid
  output reg           s_awready,     // write address ready
  input  wire [31:0]   s_wdata,       // write data
  input  wire [3:0]    s_wstrb,       // write byte strobes
  input  wire          s_wvalid,      // write data valid
  output reg           s_wready,      // write data ready
  output reg  [1:0]    s_bresp,       // write response
  output reg           s_bvalid,      // write response valid
  input  wire          s_bready,      // write response ready
  input  wire [AW-1:0] s_araddr,      // read address
  input  wire          s_arvalid,     // read address valid
  output reg           s_arready,     // read address ready
  output reg  [31:0]   s_rdata,       // read data
  output reg  [1:0]    s_rresp,       // read response
  output reg           s_rvalid,      // read data valid
  input  wire          s_rready,      // read data ready
  output wire          wr_pulse,      // one-cycle register write
  output reg  [AW-1:0] wr_addr,       // held write address
  output reg  [31:0]   wr_data,       // held write data
  output reg  [3:0]    wr_strb,       // held write strobes
  input  wire          wr_hit,        // write address is mapped
  input  wire [31:0]   rd_data,       // read data for s_araddr
  input  wire          rd_hit         // read address is mapped
);

  reg have_aw_r;
  reg have_w_r;

  assign wr_pulse = have_aw_r & have_w_r & ~s_bvalid;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      have_aw_r <= 1'b0;
      have_w_r  <= 1'b0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= `RESP_OKAY;
      wr_addr   <= {AW{1'b0}};
      wr_data   <= 32'h0;
      wr_strb   <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        have_aw_r <= 1'b1;
        s_awready <= 1'b0;
        wr_addr   <= s_awaddr;
      end else if (!have_aw_r && !s_bvalid) begin
        s_awready <= 1'b1;
      end
      if (s_wvalid && s_wready) begin
        have_w_r <= 1'b1;
        s_wready <= 1'b0;
        wr_data  <= s_wdata;
        wr_strb  <= s_wstrb;
      end else if (!have_w_r && !s_bvalid) begin
        s_wready <= 1'b1;
      end
      if (wr_pulse) begin
        have_aw_r <= 1'b0;
        have_w_r  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // read data is captured at the address handshake, so it stays stable
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0;
      s_rresp   <= `RESP_OKAY;
    end else if (s_rvalid) begin
      if (s_rready) begin
        s_rvalid  <= 1'b0;
        s_arready <= 1'b1;
      end
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rdata   <= rd_hit ? rd_data : 32'h0;
      s_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else begin
      s_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// File: test/host_bus_model.sv
// external host bus: drives the port pads, releases the lines it reads
// assumes design drive wins wherever pin_oe_n is low
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
  input  wire logic        sys_clk,  // system clock
  input  wire logic [15:0] pin_out,  // design drive values
  input  wire logic [15:0] pin_oe_n, // design enables, low drives
  output var  logic [15:0] pin_in    // resolved pad levels
);
  logic [15:0] val_r = 16'h0000;
  logic [15:0] en_r = 16'h0000;
  logic [15:0] float_r = 16'h5555;

  // undriven pads wander so a stale level never passes for data
  always @(posedge sys_clk) begin
    float_r <= ~float_r;
  end

  // direction and strobe change together in one step
  task automatic drive(input logic [15:0] v, input logic [15:0] e);
    @(posedge sys_clk);
    val_r <= v;
    en_r <= e;
  endtask

  always @* begin
    pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & en_r & val_r) | (pin_oe_n & ~en_r & float_r);
  end
endmodule
`default_nettype wire

// File: test/host_pin_mux_properties.sv
// bus handshake, reset release and strobe relations of the pin multiplexer
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module host_pin_mux_properties #(
  parameter NPIN = 16,
  parameter AW   = 8
) (
  input wire logic            sys_clk,        // clock
  input wire logic            rst_n,          // reset, active low
  input wire logic            s_awvalid,      // aw valid
  input wire logic            s_awready,      // aw ready
  input wire logic            s_wvalid,       // w valid
  input wire logic            s_wready,       // w ready
  input wire logic            s_bvalid,       // b valid
  input wire logic            s_bready,       // b ready
  input wire logic [1:0]      s_bresp,        // b response
  input wire logic            s_arvalid,      // ar valid
  input wire logic            s_arready,      // ar ready
  input wire logic            s_rvalid,       // r valid
  input wire logic            s_rready,       // r ready
  input wire logic [31:0]     s_rdata,        // r data
  input wire logic [NPIN-1:0] pin_oe_n,       // pad enables
  input wire logic            data_strobe_r,  // any data strobe
  input wire logic            read_strobe_r,  // read cycle
  input wire logic            write_strobe_r  // write cycle
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_RESET_RELEASE_HIZ: assert property ($rose(rst_n) |-> &pin_oe_n)
    else $error("pins driven at reset release");
  AST_WRITE_ANSWER: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
    else $error("write response late");
  AST_READ_ANSWER: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read response late");
  AST_BRESP_HOLD: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  AST_RDATA_HOLD: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  AST_READ_BLOCKED: assert property (s_rvalid |-> !s_arready)
    else $error("read taken while one pending");
  AST_AW_DROPS: assert property (s_awvalid && s_awready |=> !s_awready)
    else $error("second write address taken");
  AST_CYCLE_NEEDS_STROBE: assert property (read_strobe_r || write_strobe_r |-> data_strobe_r)
    else $error("cycle type without data strobe");
endmodule

bind host_port_pin_mux host_pin_mux_properties #(.NPIN(NPIN), .AW(AW)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_bready(s_bready),
  .s_bresp(s_bresp), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
  .s_rready(s_rready), .s_rdata(s_rdata), .pin_oe_n(pin_oe_n), .data_strobe_r(data_strobe_r),
  .read_strobe_r(read_strobe_r), .write_strobe_r(write_strobe_r));
`default_nettype wire

// File: test/tb_host_port_pin_mux.sv
// self-checking bench for the host pin multiplexer
// assumes host_bus_model on the pads and the bound checker
`timescale 1ns/10ps
`default_nettype none
`include "host_pin_consts.vh"
module tb_host_port_pin_mux;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00, core_rdata = 8'h5a;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0;
  logic        s_rready = 1'b0, req_single = 1'b1, req_tx = 1'b1, req_rx = 1'b0;
  logic [31:0] s_wdata = 32'h0, rd;
  logic [3:0]  s_wstrb = 4'hf;
  logic [1:0]  rsp;
  wire logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  wire logic [1:0]  s_bresp, s_rresp;
  wire logic [31:0] s_rdata;
  wire logic [15:0] pin_in, pin_out, pin_oe_n;
  wire logic [7:0]  host_byte_r;
  wire logic [10:0] host_addr_r;
  wire logic as_w, rw_w, ds_w, rs_w, ws_w, cs_w, ack_w;
  wire logic [6:0]  fl = {as_w, rw_w, ds_w, rs_w, ws_w, cs_w, ack_w};
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;

  always #50 sys_clk = ~sys_clk;

  host_port_pin_mux u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .core_rdata(core_rdata),
    .req_single(req_single), .req_tx(req_tx), .req_rx(req_rx), .host_byte_r(host_byte_r),
    .host_addr_r(host_addr_r), .addr_strobe_r(as_w), .rw_read_r(rw_w), .data_strobe_r(ds_w),
    .read_strobe_r(rs_w), .write_strobe_r(ws_w), .chip_sel_r(cs_w), .host_ack_r(ack_w));

  host_bus_model u_host (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_in(pin_in));

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // run should need well under 2000 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      $display("MISMATCH t=%0t timeout", $time);
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge sys_clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (s_awvalid && s_awready === 1'b1) aw_ok = 1'b1;
      if (s_wvalid && s_wready === 1'b1) w_ok = 1'b1;
      if (aw_ok) s_awvalid <= 1'b0;
      if (w_ok) s_wvalid <= 1'b0;
    end
    while (s_bvalid !== 1'b1) @(posedge sys_clk);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge sys_clk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_rvalid !== 1'b1);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask

  // two sync flops plus the output register
  task automatic pads(input logic [15:0] v, input logic [15:0] e);
    u_host.drive(v, e);
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic t_regs;
    for (int i = 0; i < 3; i++) begin
      axi_rd(8'(4 * i), rd, rsp);
      chk(rd, 32'h0, "reset value");
    end
    axi_rd(8'h18, rd, rsp);
    chk({30'h0, rsp}, {30'h0, `RESP_SLVERR}, "unmapped read");
    axi_wr(8'h18, 32'h1, rsp);
    chk({30'h0, rsp}, {30'h0, `RESP_SLVERR}, "unmapped write");
    $display("test regs done");
  endtask

  task automatic t_gpio;
    logic [15:0] dir, gp, pol, hv;
    dir = 16'ha5c3;
    gp = 16'h3c0f;
    pol = 16'h0ff0;
    hv = 16'h1234;
    axi_wr(`OFS_PIN_POL, {16'h0, pol}, rsp);
    axi_wr(`OFS_PIN_DIR, {16'h0, dir}, rsp);
    axi_wr(`OFS_GPIO_OUT, {16'h0, gp}, rsp);
    chk({30'h0, rsp}, {30'h0, `RESP_OKAY}, "mapped write");
    pads(hv, ~dir);
    chk({16'h0, pin_oe_n}, {16'h0, ~dir}, "gpio enables");
    chk({16'h0, pin_out}, {16'h0, gp ^ pol}, "gpio drive");
    axi_rd(`OFS_PIN_LEVEL, rd, rsp);
    chk(rd, {16'h0, (((gp ^ pol) & dir) | (hv & ~dir)) ^ pol}, "pin level");
    axi_rd(`OFS_PIN_DIR, rd, rsp);
    chk(rd, {16'h0, dir}, "dir readback");
    $display("test gpio done");
  endtask

  task automatic t_nonmux;
    axi_wr(`OFS_PIN_POL, 32'h0, rsp);
    axi_wr(`OFS_PORT_CTRL, 32'h1, rsp);
    pads(16'hbd00, 16'hbf00);
    chk({21'h0, host_addr_r}, 32'h5, "address 0..2");
    chk({25'h0, fl}, 32'h3b, "read cycle flags");
    chk({16'h0, pin_oe_n[7:0], pin_out[7:0]}, {24'h0, core_rdata}, "read drive");
    chk({30'h0, pin_oe_n[14], pin_out[14]}, 32'h1, "push-pull request");
    req_single <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({31'h0, pin_out[14]}, 32'h0, "request withdrawn");
    req_single <= 1'b1;
    pads(16'hb5a3, 16'hbfff);
    chk({25'h0, fl}, 32'h17, "write cycle flags");
    // our read drive holds the lines until three edges after the read ends
    repeat (3) @(posedge sys_clk);
    chk({24'h0, host_byte_r}, 32'ha3, "written byte");
    pads(16'h9d00, 16'hbf00);
    chk({24'h0, pin_oe_n[7:0]}, 32'hff, "no drive unselected");
    $display("test nonmux done");
  endtask

  task automatic t_mux;
    axi_wr(`OFS_PIN_POL, 32'h100, rsp);
    axi_wr(`OFS_PORT_CTRL, 32'h7, rsp);
    pads(16'h226e, 16'hbfff);
    chk({25'h0, fl}, 32'h42, "address strobe low");
    pads(16'h2311, 16'hbfff);
    chk({25'h0, fl}, 32'h02, "address strobe off");
    pads(16'h2b00, 16'hbf00);
    chk({21'h0, host_addr_r}, 32'h56e, "latched address");
    chk({25'h0, fl}, 32'h1a, "read strobe");
    chk({16'h0, pin_oe_n[7:0], pin_out[7:0]}, {24'h0, core_rdata}, "mux read drive");
    pads(16'h33c4, 16'hbfff);
    chk({25'h0, fl}, 32'h16, "write strobe");
    repeat (3) @(posedge sys_clk);
    chk({24'h0, host_byte_r}, 32'hc4, "mux byte");
    axi_wr(`OFS_PORT_CTRL, 32'h1f, rsp);
    repeat (3) @(posedge sys_clk);
    chk({28'h0, pin_oe_n[15:14], pin_out[15:14]}, 32'h4, "open-drain requests");
    $display("test mux done");
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    chk({16'h0, pin_oe_n}, 32'hffff, "released in reset");
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_gpio();
    t_nonmux();
    t_mux();
    print_verdict();
  end
endmodule
`default_nettype wire
